// ### logic/bdsr_pkg.sv
// package for the buffer delay status register bank
// assumes a plain strobe register port with 32-bit data and byte offsets
package bdsr_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          RX_DEPTH_DEF    = 6;
   localparam int          TX_RES_W        = 16;
   localparam int          PERIOD_W        = 8;
   localparam int          SYNC_STAGES     = 3;

   localparam logic [7:0]  OFS_RX_BUF      = 8'h4c;
   localparam logic [7:0]  OFS_TX_EX       = 8'h50;
   localparam logic [7:0]  OFS_RX_EX       = 8'h54;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h80;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h84;

   localparam int          POS_RESYNC      = 24;
   localparam int          POS_BYTE_DLY    = 16;
   localparam int          POS_PERIOD      = 24;
   localparam int          POS_FRESH       = 23;

   localparam int          IRQ_W           = 2;
   localparam int          IRQ_TX_NEW      = 0;
   localparam int          IRQ_RX_NEW      = 1;

   localparam logic        BIT_RST         = 1'b0;
   localparam logic [7:0]  PERIOD_RST      = 8'h00;
   localparam logic [1:0]  IRQ_RST         = 2'h0;
   localparam logic [31:0] RD_ZERO         = 32'h0000_0000;
endpackage : bdsr_pkg

// ### logic/bdsr_sync_if.sv
// interface carrying a bundle of asynchronous levels and their synchronised copy
// assumes one clock domain on the consumer side
`timescale 1ns/1ps
`default_nettype none
interface bdsr_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport syn (input raw, output clean);
   modport usr (output raw, input clean);
endinterface : bdsr_sync_if
`default_nettype wire

// ### logic/bdsr_sync.sv
// three-stage synchroniser for a bundle of inputs from outside the clock domain
// assumes the bundle holds values that are stable for several cycles
`timescale 1ns/1ps
`default_nettype none
module bdsr_sync #(
   parameter int W = 1
) (
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  ce,
   bdsr_sync_if.syn   sif
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } bdsr_sync_st_t;

   bdsr_sync_st_t st_r;
   bdsr_sync_st_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = sif.raw;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // accept a change once stages two and three agree
      if (st_r.s2 == st_r.s3) begin
         st_nxt.out = st_r.s3;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign sif.clean = st_r.out;
endmodule : bdsr_sync
`default_nettype wire

// ### logic/bdsr_regs.sv
// register bank for receive buffer fill level, resync control and extended delay results
// assumes status inputs come from other clock domains and new-result flags toggle per result
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - writing one to bit 24 of the receive delay register while it holds zero pulses a receive pointer resync.
// - bit 16 of the receive delay register shows the current byte-alignment delay.
// - the low field of the receive delay register shows the receive buffer fill level.
// - bits 31:24 of the transmit extended delay register hold the transmit period N.
// - bit 23 of the transmit extended delay register sets on a new result, clears on read.
// - bits 15:0 of the transmit extended delay register hold the transmit result.
// - bits 31:24 of the receive extended delay register hold the receive period.
// - bit 23 of the receive extended delay register sets on a new result, clears on read.
// - the low field of the receive extended delay register holds the receive result.
module bdsr_regs #(
   parameter int RX_DEPTH = bdsr_pkg::RX_DEPTH_DEF
) (
   input  wire logic                         SYS_CLK,
   input  wire logic                         RST,
   input  wire logic                         CE,
   input  wire logic [bdsr_pkg::ADDR_W-1:0]  ADDR,
   input  wire logic [bdsr_pkg::DATA_W-1:0]  WDATA,
   input  wire logic                         WR_STB,
   input  wire logic                         RD_STB,
   output logic      [bdsr_pkg::DATA_W-1:0]  RDATA,
   input  wire logic [RX_DEPTH-1:0]          RX_FILL_LEVEL,
   input  wire logic                         RX_BYTE_ALIGN_DELAY,
   input  wire logic                         LINE_RATE_CHANGE,
   input  wire logic [bdsr_pkg::TX_RES_W-1:0] TRANSMIT_EXTENDED_LATENCY_RESULT,
   input  wire logic                         TRANSMIT_RESULT_TOGGLE,
   input  wire logic [RX_DEPTH-1:0]          RECEIVE_EXTENDED_LATENCY_RESULT,
   input  wire logic                         RECEIVE_RESULT_TOGGLE,
   output logic [bdsr_pkg::PERIOD_W-1:0]     TX_PERIOD,
   output logic [bdsr_pkg::PERIOD_W-1:0]     RX_PERIOD,
   output logic                              RX_RESYNC,
   output logic                              IRQ
);
   localparam int SW = RX_DEPTH + 1 + 1 + 1 + bdsr_pkg::TX_RES_W + 1 + RX_DEPTH;
   // cycles until the synchronised copy reflects the pins after reset
   localparam int SETTLE_CYC = bdsr_pkg::SYNC_STAGES + 2;
   localparam int SETTLE_W   = $clog2(SETTLE_CYC + 1);

   typedef struct packed {
      logic [bdsr_pkg::PERIOD_W-1:0] tx_period;
      logic [bdsr_pkg::PERIOD_W-1:0] rx_period;
      logic                          resync_req;
      logic                          resync;
      logic                          rate_d;
      logic                          tx_tog_d;
      logic                          rx_tog_d;
      logic [SETTLE_W-1:0]           settle;
      logic                          transmit_result_fresh;
      logic                          receive_result_fresh;
      logic [bdsr_pkg::TX_RES_W-1:0] transmit_extended_latency_result;
      logic [RX_DEPTH-1:0]           receive_extended_latency_result;
      logic [bdsr_pkg::IRQ_W-1:0]    irq_stat;
      logic [bdsr_pkg::IRQ_W-1:0]    irq_mask;
      logic [bdsr_pkg::DATA_W-1:0]   rdata;
   } bdsr_st_t;

   bdsr_st_t st_r;
   bdsr_st_t st_nxt;

   logic [SW-1:0] sync_clean;

   bdsr_sync_if #(.W(SW)) sif ();

   assign sif.raw = {RX_FILL_LEVEL, RX_BYTE_ALIGN_DELAY, LINE_RATE_CHANGE,
                     TRANSMIT_RESULT_TOGGLE, TRANSMIT_EXTENDED_LATENCY_RESULT,
                     RECEIVE_RESULT_TOGGLE, RECEIVE_EXTENDED_LATENCY_RESULT};
   assign sync_clean = sif.clean;

   bdsr_sync #(.W(SW)) u_sync (
      .clk (SYS_CLK),
      .rst (RST),
      .ce  (CE),
      .sif (sif)
   );

   logic [RX_DEPTH-1:0]           s_fill;
   logic                          s_byte;
   logic                          s_rate;
   logic                          s_tx_tog;
   logic [bdsr_pkg::TX_RES_W-1:0] s_tx_res;
   logic                          s_rx_tog;
   logic [RX_DEPTH-1:0]           s_rx_res;

   assign {s_fill, s_byte, s_rate, s_tx_tog, s_tx_res, s_rx_tog, s_rx_res} = sync_clean;

   always_comb begin
      logic                             tx_new;
      logic                             rx_new;
      logic [bdsr_pkg::DATA_W-1:0]      rd;
      logic [bdsr_pkg::IRQ_W-1:0]       ev;
      logic                             warm;
      tx_new = 1'b0;
      rx_new = 1'b0;
      rd     = bdsr_pkg::RD_ZERO;
      ev     = bdsr_pkg::IRQ_RST;
      warm   = 1'b0;
      st_nxt = st_r;

      // no edge detection until the synchroniser output is valid, so a toggle
      // or rate level already high at reset release gives no false event
      warm = (st_r.settle == SETTLE_W'(SETTLE_CYC));
      if (!warm) begin
         st_nxt.settle = st_r.settle + SETTLE_W'(1);
      end

      tx_new = warm && (s_tx_tog ^ st_r.tx_tog_d);
      rx_new = warm && (s_rx_tog ^ st_r.rx_tog_d);
      st_nxt.tx_tog_d = s_tx_tog;
      st_nxt.rx_tog_d = s_rx_tog;
      st_nxt.rate_d   = s_rate;

      // read data and read-clear effects
      if (RD_STB) begin
         case (ADDR)
            bdsr_pkg::OFS_RX_BUF: begin
               rd[bdsr_pkg::POS_RESYNC]   = st_r.resync_req;
               rd[bdsr_pkg::POS_BYTE_DLY] = s_byte;
               rd[RX_DEPTH-1:0]           = s_fill;
            end
            bdsr_pkg::OFS_TX_EX: begin
               rd[bdsr_pkg::POS_PERIOD +: bdsr_pkg::PERIOD_W] = st_r.tx_period;
               rd[bdsr_pkg::POS_FRESH] = st_r.transmit_result_fresh;
               rd[bdsr_pkg::TX_RES_W-1:0] = st_r.transmit_extended_latency_result;
               st_nxt.transmit_result_fresh = 1'b0;
            end
            bdsr_pkg::OFS_RX_EX: begin
               rd[bdsr_pkg::POS_PERIOD +: bdsr_pkg::PERIOD_W] = st_r.rx_period;
               rd[bdsr_pkg::POS_FRESH] = st_r.receive_result_fresh;
               rd[RX_DEPTH-1:0] = st_r.receive_extended_latency_result;
               st_nxt.receive_result_fresh = 1'b0;
            end
            bdsr_pkg::OFS_IRQ_STATUS: begin
               rd[bdsr_pkg::IRQ_W-1:0] = st_r.irq_stat;
               st_nxt.irq_stat         = bdsr_pkg::IRQ_RST;
            end
            bdsr_pkg::OFS_IRQ_MASK: begin
               rd[bdsr_pkg::IRQ_W-1:0] = st_r.irq_mask;
            end
            default: begin
               rd = bdsr_pkg::RD_ZERO;
            end
         endcase
      end
      st_nxt.rdata = rd;

      // writes touch only the writable fields
      if (WR_STB) begin
         case (ADDR)
            bdsr_pkg::OFS_RX_BUF: begin
               st_nxt.resync_req = WDATA[bdsr_pkg::POS_RESYNC];
            end
            bdsr_pkg::OFS_TX_EX: begin
               st_nxt.tx_period = WDATA[bdsr_pkg::POS_PERIOD +: bdsr_pkg::PERIOD_W];
            end
            bdsr_pkg::OFS_RX_EX: begin
               st_nxt.rx_period = WDATA[bdsr_pkg::POS_PERIOD +: bdsr_pkg::PERIOD_W];
            end
            bdsr_pkg::OFS_IRQ_MASK: begin
               st_nxt.irq_mask = WDATA[bdsr_pkg::IRQ_W-1:0];
            end
            default: begin
               st_nxt.irq_mask = st_r.irq_mask;
            end
         endcase
      end

      // resync pulse on a rising write of the bit or on a line rate change
      st_nxt.resync = (WR_STB && ADDR == bdsr_pkg::OFS_RX_BUF &&
                       WDATA[bdsr_pkg::POS_RESYNC] && !st_r.resync_req)
                      || (warm && s_rate && !st_r.rate_d);

      // new results load, fresh flag set wins over read clear
      if (tx_new) begin
         st_nxt.transmit_extended_latency_result = s_tx_res;
         st_nxt.transmit_result_fresh            = 1'b1;
      end
      if (rx_new) begin
         st_nxt.receive_extended_latency_result = s_rx_res;
         st_nxt.receive_result_fresh            = 1'b1;
      end
      ev[bdsr_pkg::IRQ_TX_NEW] = tx_new;
      ev[bdsr_pkg::IRQ_RX_NEW] = rx_new;
      st_nxt.irq_stat = st_nxt.irq_stat | ev;
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         st_r <= '0;
      end else if (CE) begin
         st_r <= st_nxt;
      end
   end

   assign RDATA     = st_r.rdata;
   assign TX_PERIOD = st_r.tx_period;
   assign RX_PERIOD = st_r.rx_period;
   assign RX_RESYNC = st_r.resync;
   assign IRQ       = |(st_r.irq_stat & st_r.irq_mask);
endmodule : bdsr_regs
`default_nettype wire

// ### verif/bdsr_chk.sv
// assertions for the buffer delay status register bank
// assumes a bind onto every instance of the register bank top
`timescale 1ns/1ps
`default_nettype none
module bdsr_chk #(
   parameter int RX_DEPTH = bdsr_pkg::RX_DEPTH_DEF
) (
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic        CE,
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR_STB,
   input wire logic        RD_STB,
   input wire logic [31:0] RDATA,
   input wire logic [7:0]  TX_PERIOD,
   input wire logic [7:0]  RX_PERIOD,
   input wire logic        RX_RESYNC
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   logic       bit_r;
   logic       wr_rx;
   logic       wr_tx;
   logic       wr_ex;
   logic       rd;
   logic [7:0] wd_hi;
   assign wr_rx = CE && WR_STB && ADDR == 8'h4c;
   assign wr_tx = CE && WR_STB && ADDR == 8'h50;
   assign wr_ex = CE && WR_STB && ADDR == 8'h54;
   assign rd = CE && RD_STB;
   assign wd_hi = WDATA[31:24];
   // stored resync bit, a rising write must give a pulse
   always_ff @(posedge SYS_CLK or posedge RST)
      if (RST) bit_r <= 1'b0;
      else if (wr_rx) bit_r <= WDATA[24];
   a_resync_on_write: assert property (wr_rx && WDATA[24] && !bit_r |=> RX_RESYNC)
      else $error("no resync pulse after write");
   a_resync_one_cycle: assert property (RX_RESYNC |=> !RX_RESYNC)
      else $error("resync pulse too long");
   a_tx_period_set: assert property (wr_tx |=> TX_PERIOD == $past(wd_hi))
      else $error("tx period not written");
   a_tx_period_hold: assert property (!wr_tx |=> $stable(TX_PERIOD))
      else $error("tx period changed");
   a_rx_period_set: assert property (wr_ex |=> RX_PERIOD == $past(wd_hi))
      else $error("rx period not written");
   a_rx_period_hold: assert property (!wr_ex |=> $stable(RX_PERIOD))
      else $error("rx period changed");
   a_unmapped_zero: assert property (rd && !(ADDR inside {8'h4c, 8'h50, 8'h54, 8'h80, 8'h84})
      |=> RDATA == 32'h0)
      else $error("unmapped read not zero");
   a_rx_reserved: assert property (rd && ADDR == 8'h4c |=> RDATA[31:25] == 7'h0 &&
      RDATA[23:17] == 7'h0 && (RDATA[15:0] >> RX_DEPTH) == 16'h0)
      else $error("reserved bits set");
   a_tx_period_read: assert property (rd && ADDR == 8'h50 |=>
      RDATA[31:24] == $past(TX_PERIOD) && RDATA[22:16] == 7'h0)
      else $error("tx register read wrong");
   c_resync: cover property (RX_RESYNC);
   c_tx_fresh: cover property (rd && ADDR == 8'h50 ##1 RDATA[23]);
   c_rx_write: cover property (wr_ex);
endmodule // bdsr_chk
bind bdsr_regs bdsr_chk #(.RX_DEPTH(RX_DEPTH)) i_chk (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE),
   .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
   .TX_PERIOD(TX_PERIOD), .RX_PERIOD(RX_PERIOD), .RX_RESYNC(RX_RESYNC));
`default_nettype wire

// ### verif/tb_top.sv
// self-checking testbench for the buffer delay status register bank
// assumes one clock, reads answered in the next cycle, mask bit one enables
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk, rst, wr, rd, brk, lrc, ttg, rtg, rs_seen;
   logic [7:0]  addr, tper, rper;
   logic [31:0] wd, rdv;
   logic [5:0]  fill, rres;
   logic [15:0] tres;
   logic        rsy, irq;
   int          err_count = 0;
   int          num_checks = 0;
   bdsr_regs #(.RX_DEPTH(6)) i_dut (.SYS_CLK(clk), .RST(rst), .CE(1'b1), .ADDR(addr),
      .WDATA(wd), .WR_STB(wr), .RD_STB(rd), .RDATA(rdv), .RX_FILL_LEVEL(fill),
      .RX_BYTE_ALIGN_DELAY(brk), .LINE_RATE_CHANGE(lrc),
      .TRANSMIT_EXTENDED_LATENCY_RESULT(tres), .TRANSMIT_RESULT_TOGGLE(ttg),
      .RECEIVE_EXTENDED_LATENCY_RESULT(rres), .RECEIVE_RESULT_TOGGLE(rtg),
      .TX_PERIOD(tper), .RX_PERIOD(rper), .RX_RESYNC(rsy), .IRQ(irq));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
      rs_seen = rsy;
   endtask
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(n, rdv, e);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #20000;
      err_count++;
      test_done();
   end
   initial begin
      {rst, wr, rd, brk, lrc, ttg, rtg} = 7'h40;
      {addr, wd, fill, rres, tres} = '0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_chk("rx_buf reset", 8'h4c, 32'h0);
      rd_chk("tx_ex reset", 8'h50, 32'h0);
      rd_chk("rx_ex reset", 8'h54, 32'h0);
      rd_chk("unmapped", 8'h3c, 32'h0);
      $display("test reset done");
      wr_reg(8'h50, 32'hffff_ffff);
      wr_reg(8'h54, 32'ha5ff_ffff);
      chk("tx period", {24'h0, tper}, 32'hff);
      chk("rx period", {24'h0, rper}, 32'ha5);
      rd_chk("tx_ex ro", 8'h50, 32'hff00_0000);
      rd_chk("rx_ex ro", 8'h54, 32'ha500_0000);
      $display("test periods done");
      fill <= 6'h2a;
      brk <= 1'b1;
      wr_reg(8'h4c, 32'hffff_ffff);
      chk("resync pulse", {31'h0, rs_seen}, 32'h1);
      repeat (6) @(posedge clk);
      #1;
      chk("resync low", {31'h0, rsy}, 32'h0);
      rd_chk("rx_buf", 8'h4c, 32'h0101_002a);
      wr_reg(8'h4c, 32'h0);
      @(posedge clk);
      lrc <= 1'b1;
      rs_seen = 1'b0;
      repeat (8) begin
         @(posedge clk);
         #1;
         rs_seen = rs_seen | rsy;
      end
      chk("auto resync", {31'h0, rs_seen}, 32'h1);
      $display("test resync done");
      wr_reg(8'h84, 32'h3);
      tres <= 16'h8001;
      rres <= 6'h3f;
      repeat (5) @(posedge clk);
      ttg <= 1'b1;
      rtg <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk("irq raised", {31'h0, irq}, 32'h1);
      rd_chk("tx fresh", 8'h50, 32'hff80_8001);
      rd_chk("tx cleared", 8'h50, 32'hff00_8001);
      rd_chk("rx fresh", 8'h54, 32'ha580_003f);
      rd_chk("rx cleared", 8'h54, 32'ha500_003f);
      rd_chk("irq status", 8'h80, 32'h3);
      rd_chk("irq cleared", 8'h80, 32'h0);
      chk("irq low", {31'h0, irq}, 32'h0);
      wr_reg(8'h84, 32'h2);
      rd_chk("irq mask", 8'h84, 32'h2);
      @(posedge clk);
      ttg <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("irq masked", {31'h0, irq}, 32'h0);
      rd_chk("masked status", 8'h80, 32'h1);
      $display("test results done");
      test_done();
   end
endmodule // tb_top
`default_nettype wire
